// ### logic/rftx_pkg.sv
// package with register map, field positions and codes of the transmitter config bank
package rftx_pkg;
  // register offsets (byte addresses on the 8-bit register port)
  localparam logic [7:0] ADDR_DRIVE_MODE = 8'h28;
  localparam logic [7:0] ADDR_AMPLITUDE  = 8'h29;
  localparam logic [7:0] ADDR_MOD_CTRL   = 8'h2a;
  localparam logic [7:0] ADDR_OVS_LOAD   = 8'h2b;
  // reset values
  localparam logic [7:0] RST_DRIVE_MODE  = 8'h00;
  localparam logic [7:0] RST_AMPLITUDE   = 8'h00;
  localparam logic [7:0] RST_MOD_CTRL    = 8'h00;
  localparam logic [7:0] RST_OVS_LOAD    = 8'h00;
  // drive mode fields
  localparam int BIT_OUT_B_INVERT   = 7;
  localparam int BIT_OUT_A_INVERT   = 6;
  localparam int BIT_OUTPUTS_ENABLE = 3;
  localparam int POS_DRIVE_STYLE    = 0;
  localparam logic [7:0] MASK_DRIVE_MODE = 8'hcf;
  // amplitude fields
  localparam int POS_LEVEL_REDUCTION = 6;
  localparam int POS_RESIDUAL        = 0;
  localparam logic [7:0] MASK_AMPLITUDE = 8'hdf;
  // modulation control fields
  localparam int POS_OVERSHOOT_B = 4;
  localparam int BIT_CARRIER_MAX = 3;
  localparam int BIT_MOD_INVERT  = 2;
  localparam int POS_MOD_SOURCE  = 0;
  // overshoot and load fields
  localparam int POS_OVERSHOOT_A = 4;
  localparam int POS_LOAD_TRIM   = 0;
  // unsupported drive style codes
  localparam logic [2:0] STYLE_BAD_A = 3'h3;
  localparam logic [2:0] STYLE_BAD_B = 3'h6;
  // carrier reduction in millivolts per code
  localparam logic [10:0] REDUCE_MV_0 = 11'h064;
  localparam logic [10:0] REDUCE_MV_1 = 11'h0fa;
  localparam logic [10:0] REDUCE_MV_2 = 11'h1f4;
  localparam logic [10:0] REDUCE_MV_3 = 11'h3e8;
  // modulation sources
  typedef enum logic [1:0] {
    RFTX_SRC_NONE     = 2'h0,
    RFTX_SRC_ENVELOPE = 2'h1,
    RFTX_SRC_EXTERNAL = 2'h2,
    RFTX_SRC_RESERVED = 2'h3
  } rftx_source_type;
  // overshoot pulse sequencer states
  typedef enum logic [2:0] {
    RFTX_OVS_IDLE = 3'b001,
    RFTX_OVS_A    = 3'b010,
    RFTX_OVS_B    = 3'b100
  } rftx_ovs_type;
endpackage : rftx_pkg

// ### logic/rftx_overshoot.sv
// overshoot pulse sequencer run on the carrier clock tick
`timescale 1ns/1ps
module rftx_overshoot
  import rftx_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic       carrierTick,
  input  wire logic       modEdge,
  input  wire logic [3:0] lenA,
  input  wire logic [3:0] lenB,
  output logic            overshootActive
);
  rftx_ovs_type state;
  rftx_ovs_type next_state;
  logic [3:0]   count;
  logic [3:0]   next_count;

  // phase a then phase b, each counting carrier ticks; zero length skips it
  always_comb
  begin
    next_state = state;
    next_count = count;
    case (state)
      RFTX_OVS_IDLE:
      begin
        if (modEdge && lenA != 4'h0)
        begin
          next_state = RFTX_OVS_A;
          next_count = lenA;
        end
        else if (modEdge && lenB != 4'h0)
        begin
          next_state = RFTX_OVS_B;
          next_count = lenB;
        end
      end
      RFTX_OVS_A:
      begin
        if (carrierTick)
        begin
          if (count == 4'h1)
          begin
            next_state = (lenB != 4'h0) ? RFTX_OVS_B : RFTX_OVS_IDLE;
            next_count = lenB;
          end
          else
          begin
            next_count = count - 4'h1;
          end
        end
      end
      RFTX_OVS_B:
      begin
        if (carrierTick)
        begin
          if (count == 4'h1)
          begin
            next_state = RFTX_OVS_IDLE;
            next_count = 4'h0;
          end
          else
          begin
            next_count = count - 4'h1;
          end
        end
      end
      default:
      begin
        next_state = RFTX_OVS_IDLE;
        next_count = 4'h0;
      end
    endcase
  end

  // state registers
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= RFTX_OVS_IDLE;
      count <= 4'h0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
    end
  end

  assign overshootActive = (state != RFTX_OVS_IDLE);
endmodule : rftx_overshoot

// ### logic/rftx_config_regs.sv
// transmitter configuration register bank and antenna output control
`timescale 1ns/1ps
module rftx_config_regs
  import rftx_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrStrobe,
  input  wire logic        regRdStrobe,
  output logic      [7:0]  regRdData,
  input  wire logic        carrierIn,
  input  wire logic        internalEnvelope,
  input  wire logic        externalSignalIn,
  output logic             antennaOutA,
  output logic             antennaOutAOe,
  output logic             antennaOutB,
  output logic             antennaOutBOe,
  output logic      [10:0] carrierLevelReductionMv,
  output logic             carrierFull,
  output logic      [4:0]  residualCarrier,
  output logic      [3:0]  loadCurrentTrim,
  output logic             modulationActive,
  output logic             overshootActive,
  output logic             driveStyleFault
);
  logic [7:0] txDriveMode;
  logic [7:0] txAmplitude;
  logic [7:0] txModulationControl;
  logic [7:0] txOvershootLoad;
  logic [7:0] next_txDriveMode;
  logic [7:0] next_txAmplitude;
  logic [7:0] next_txModulationControl;
  logic [7:0] next_txOvershootLoad;
  logic [7:0] next_regRdData;

  // two-flop synchronisers for pins from outside the clock domain
  logic [2:0] syncMeta;
  logic [2:0] syncOut;
  logic       carrierPrev;
  logic       modPrev;

  logic [2:0] outputDriveStyle;
  logic [1:0] carrierLevelCode;
  logic [3:0] overshootLenA;
  logic [3:0] overshootLenB;
  logic       modulationInvert;
  logic       outputsEnable;
  logic       outAInvert;
  logic       outBInvert;
  logic       carrierSync;
  logic       envelopeSync;
  logic       externalSync;
  logic       carrierTick;
  logic       rawModulation;
  logic       modulation;
  logic       modEdge;
  logic       driveLevel;
  logic       levelA;
  logic       levelB;
  logic [10:0] reductionMv;
  rftx_source_type modulationSource;
  logic [10:0] next_carrierLevelReductionMv;
  logic        next_carrierFull;
  logic [4:0]  next_residualCarrier;
  logic [3:0]  next_loadCurrentTrim;
  logic        next_modulationActive;
  logic        next_driveStyleFault;

  // register writes; fields with reserved positions drop those bits
  always_comb
  begin
    next_txDriveMode         = txDriveMode;
    next_txAmplitude         = txAmplitude;
    next_txModulationControl = txModulationControl;
    next_txOvershootLoad     = txOvershootLoad;
    if (regWrStrobe)
    begin
      case (regAddr)
        ADDR_DRIVE_MODE: next_txDriveMode = regWrData & MASK_DRIVE_MODE;
        ADDR_AMPLITUDE:  next_txAmplitude = regWrData & MASK_AMPLITUDE;
        ADDR_MOD_CTRL:   next_txModulationControl = regWrData;
        ADDR_OVS_LOAD:   next_txOvershootLoad = regWrData;
        default:         next_txDriveMode = txDriveMode;
      endcase
    end
  end

  // read data valid in the cycle after the strobe; unmapped reads give zero
  always_comb
  begin
    next_regRdData = 8'h00;
    if (regRdStrobe)
    begin
      case (regAddr)
        ADDR_DRIVE_MODE: next_regRdData = txDriveMode;
        ADDR_AMPLITUDE:  next_regRdData = txAmplitude;
        ADDR_MOD_CTRL:   next_regRdData = txModulationControl;
        ADDR_OVS_LOAD:   next_regRdData = txOvershootLoad;
        default:         next_regRdData = 8'h00;
      endcase
    end
  end

  // register bank and read data
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      txDriveMode         <= RST_DRIVE_MODE;
      txAmplitude         <= RST_AMPLITUDE;
      txModulationControl <= RST_MOD_CTRL;
      txOvershootLoad     <= RST_OVS_LOAD;
      regRdData           <= 8'h00;
    end
    else
    begin
      txDriveMode         <= next_txDriveMode;
      txAmplitude         <= next_txAmplitude;
      txModulationControl <= next_txModulationControl;
      txOvershootLoad     <= next_txOvershootLoad;
      regRdData           <= next_regRdData;
    end
  end

  // field extraction
  // output b invert
  assign outBInvert       = txDriveMode[BIT_OUT_B_INVERT];
  assign outAInvert       = txDriveMode[BIT_OUT_A_INVERT];
  assign outputsEnable    = txDriveMode[BIT_OUTPUTS_ENABLE];
  assign outputDriveStyle = txDriveMode[POS_DRIVE_STYLE +: 3];
  assign carrierLevelCode = txAmplitude[POS_LEVEL_REDUCTION +: 2];
  assign overshootLenB    = txModulationControl[POS_OVERSHOOT_B +: 4];
  assign modulationInvert = txModulationControl[BIT_MOD_INVERT];
  assign modulationSource = rftx_source_type'(txModulationControl[POS_MOD_SOURCE +: 2]);
  assign overshootLenA    = txOvershootLoad[POS_OVERSHOOT_A +: 4];

  // pins are asynchronous; only the second stage is read by logic
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      syncMeta    <= 3'h0;
      syncOut     <= 3'h0;
      carrierPrev <= 1'b0;
      modPrev     <= 1'b0;
    end
    else
    begin
      syncMeta    <= {externalSignalIn, internalEnvelope, carrierIn};
      syncOut     <= syncMeta;
      carrierPrev <= carrierSync;
      modPrev     <= modulation;
    end
  end

  assign carrierSync  = syncOut[0];
  assign envelopeSync = syncOut[1];
  assign externalSync = syncOut[2];
  assign carrierTick  = carrierSync & ~carrierPrev;

  // modulation source select; reserved code behaves as no modulation
  always_comb
  begin
    case (modulationSource)
      RFTX_SRC_NONE:     rawModulation = 1'b0;
      RFTX_SRC_ENVELOPE: rawModulation = envelopeSync;
      RFTX_SRC_EXTERNAL: rawModulation = externalSync;
      default:           rawModulation = 1'b0;
    endcase
  end

  assign modulation = rawModulation ^ modulationInvert;
  assign modEdge    = modulation ^ modPrev;

  // extra modulation after each edge that finds the sequencer idle, to damp antenna overshoot
  rftx_overshoot u_overshoot
  (
    .sys_clk         (sys_clk),
    .arst_n          (arst_n),
    .carrierTick     (carrierTick),
    .modEdge         (modEdge),
    .lenA            (overshootLenA),
    .lenB            (overshootLenB),
    .overshootActive (overshootActive)
  );

  always_comb
  begin
    case (carrierLevelCode)
      2'h0:    reductionMv = REDUCE_MV_0;
      2'h1:    reductionMv = REDUCE_MV_1;
      2'h2:    reductionMv = REDUCE_MV_2;
      default: reductionMv = REDUCE_MV_3;
    endcase
  end

  // next analog control words, derived from the register fields
  always_comb
  begin
    next_carrierFull             = txModulationControl[BIT_CARRIER_MAX];
    next_carrierLevelReductionMv = next_carrierFull ? 11'h000 : reductionMv;
    next_residualCarrier         = txAmplitude[POS_RESIDUAL +: 5];
    next_loadCurrentTrim         = txOvershootLoad[POS_LOAD_TRIM +: 4];
    next_modulationActive        = modulation | overshootActive;
    next_driveStyleFault         = (outputDriveStyle == STYLE_BAD_A) ||
                                   (outputDriveStyle == STYLE_BAD_B);
  end

  // analog control words are registered so the front end sees clean levels
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      carrierLevelReductionMv <= 11'h000;
      carrierFull             <= 1'b0;
      residualCarrier         <= 5'h00;
      loadCurrentTrim         <= 4'h0;
      modulationActive        <= 1'b0;
      driveStyleFault         <= 1'b0;
    end
    else
    begin
      carrierLevelReductionMv <= next_carrierLevelReductionMv;
      carrierFull             <= next_carrierFull;
      residualCarrier         <= next_residualCarrier;
      loadCurrentTrim         <= next_loadCurrentTrim;
      modulationActive        <= next_modulationActive;
      driveStyleFault         <= next_driveStyleFault;
    end
  end

  // carrier gated by modulation; residual level is applied in the analog stage
  assign driveLevel = carrierSync & ~(modulation | overshootActive);
  assign levelA     = driveLevel ^ outAInvert;
  assign levelB     = driveLevel ^ outBInvert;

  // pin drive per style: 0 push-pull, 1 open drain, 2 hi-z, 4 high, 5 low
  always_comb
  begin
    antennaOutA   = 1'b0;
    antennaOutB   = 1'b0;
    antennaOutAOe = 1'b0;
    antennaOutBOe = 1'b0;
    if (outputsEnable)
    begin
      // drive style decode; unsupported codes stay off
      case (outputDriveStyle)
        3'h0:
        begin
          antennaOutA   = levelA;
          antennaOutB   = levelB;
          antennaOutAOe = 1'b1;
          antennaOutBOe = 1'b1;
        end
        3'h1:
        begin
          antennaOutAOe = ~levelA;
          antennaOutBOe = ~levelB;
        end
        3'h4:
        begin
          antennaOutA   = 1'b1;
          antennaOutB   = 1'b1;
          antennaOutAOe = 1'b1;
          antennaOutBOe = 1'b1;
        end
        3'h5:
        begin
          antennaOutAOe = 1'b1;
          antennaOutBOe = 1'b1;
        end
        default:
        begin
          antennaOutAOe = 1'b0;
          antennaOutBOe = 1'b0;
        end
      endcase
    end
  end
endmodule : rftx_config_regs

// ### sim/rftx_antenna_model.sv
// antenna network model: carrier source and pin pull-ups
`timescale 1ns/1ps
module rftx_antenna_model (
  input  wire logic carrierRun,
  input  wire logic antennaOutA,
  input  wire logic antennaOutAOe,
  input  wire logic antennaOutB,
  input  wire logic antennaOutBOe,
  output logic      carrierIn,
  output logic      padA,
  output logic      padB
);
  // carrier held high between bursts so pin levels stay static
  initial
  begin
    carrierIn = 1'b1;
    forever #21 carrierIn = carrierRun ? ~carrierIn : 1'b1;
  end
  assign padA = antennaOutAOe ? antennaOutA : 1'b1;
  assign padB = antennaOutBOe ? antennaOutB : 1'b1;
endmodule : rftx_antenna_model

// ### sim/rftx_config_regs_assertions.sv
// port checker for the transmitter config bank
`timescale 1ns/1ps
module rftx_config_regs_assertions
  import rftx_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic [7:0]  regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic        regWrStrobe,
  input wire logic        regRdStrobe,
  input wire logic [7:0]  regRdData,
  input wire logic        antennaOutAOe,
  input wire logic        antennaOutBOe,
  input wire logic [10:0] carrierLevelReductionMv,
  input wire logic        carrierFull,
  input wire logic [4:0]  residualCarrier,
  input wire logic [3:0]  loadCurrentTrim,
  input wire logic        driveStyleFault
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // reduction per code, kept apart from the design's table
  function automatic logic [10:0] mvOf(input logic [1:0] c);
    case (c)
      2'h0: return 11'h064;
      2'h1: return 11'h0fa;
      2'h2: return 11'h1f4;
      default: return 11'h3e8;
    endcase
  endfunction : mvOf
  // bus steps
  sequence s_wr(logic [7:0] a);
    regWrStrobe && regAddr == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    regRdStrobe && regAddr == a;
  endsequence
  property p_rw_load;
    s_wr(ADDR_OVS_LOAD) ##1 s_rd(ADDR_OVS_LOAD) |=> regRdData == $past(regWrData, 2);
  endproperty
  a_rw_load: assert property (p_rw_load) else $error("load readback wrong");
  property p_trim;
    s_wr(ADDR_OVS_LOAD) |-> ##2 loadCurrentTrim == $past(regWrData[3:0], 2);
  endproperty
  a_trim: assert property (p_trim) else $error("trim output wrong");
  property p_residual;
    s_wr(ADDR_AMPLITUDE) |-> ##2 residualCarrier == $past(regWrData[4:0], 2);
  endproperty
  a_residual: assert property (p_residual) else $error("residual wrong");
  property p_reduce;
    s_wr(ADDR_AMPLITUDE) ##2 !carrierFull
      |-> carrierLevelReductionMv == mvOf($past(regWrData[7:6], 2));
  endproperty
  a_reduce: assert property (p_reduce) else $error("reduction wrong");
  property p_full;
    s_wr(ADDR_MOD_CTRL) |-> ##2 carrierFull == $past(regWrData[3], 2)
      && (!carrierFull || carrierLevelReductionMv == 11'h000);
  endproperty
  a_full: assert property (p_full) else $error("carrier max wrong");
  property p_fault;
    s_wr(ADDR_DRIVE_MODE) |-> ##2
      driveStyleFault == ($past(regWrData[2:0], 2) inside {3'h3, 3'h6});
  endproperty
  a_fault: assert property (p_fault) else $error("style fault wrong");
  property p_oe_off;
    s_wr(ADDR_DRIVE_MODE) ##0 !regWrData[3] ##1 !regWrStrobe |-> !antennaOutAOe && !antennaOutBOe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("pins driven while off");
  property p_reserved;
    s_rd(ADDR_DRIVE_MODE) |=> regRdData[5:4] == 2'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");
endmodule : rftx_config_regs_assertions
bind rftx_config_regs rftx_config_regs_assertions rftx_config_regs_assertions_i (
  .sys_clk(sys_clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
  .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
  .antennaOutAOe(antennaOutAOe), .antennaOutBOe(antennaOutBOe),
  .carrierLevelReductionMv(carrierLevelReductionMv), .carrierFull(carrierFull),
  .residualCarrier(residualCarrier), .loadCurrentTrim(loadCurrentTrim),
  .driveStyleFault(driveStyleFault));

// ### sim/rftx_config_regs_bench.sv
// self-checking bench for the transmitter config bank
`timescale 1ns/1ps
module rftx_config_regs_bench;
  import rftx_pkg::*;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [7:0]  regWrData = 8'h00;
  logic        regWrStrobe = 1'b0;
  logic        regRdStrobe = 1'b0;
  logic        internalEnvelope = 1'b0;
  logic        externalSignalIn = 1'b0;
  logic        carrierRun = 1'b0;
  logic [7:0]  regRdData, rdVal;
  logic        carrierIn, antennaOutA, antennaOutAOe, antennaOutB, antennaOutBOe;
  logic [10:0] carrierLevelReductionMv;
  logic        carrierFull, modulationActive, overshootActive, driveStyleFault, padA, padB;
  logic [4:0]  residualCarrier;
  logic [3:0]  loadCurrentTrim;
  logic [7:0]  maskTbl[4] = '{8'hcf, 8'hdf, 8'hff, 8'hff};
  logic [10:0] mvTbl[4] = '{11'h064, 11'h0fa, 11'h1f4, 11'h3e8};
  // drive byte then padA, oeA, padB, oeB, fault
  logic [12:0] drvTbl[12] = '{{8'h08, 5'h1e}, {8'h88, 5'h1a}, {8'h48, 5'h0e},
    {8'h00, 5'h14}, {8'h0c, 5'h1e}, {8'h0d, 5'h0a}, {8'h0a, 5'h14}, {8'h0b, 5'h15},
    {8'h0e, 5'h15}, {8'h09, 5'h14}, {8'h49, 5'h0c}, {8'h0f, 5'h14}};
  logic [4:0]  pinVec;
  // control byte then envelope, external, expected modulation
  logic [10:0] modTbl[9] = '{{8'h00, 3'h6}, {8'h01, 3'h5}, {8'h01, 3'h2}, {8'h02, 3'h3},
    {8'h02, 3'h4}, {8'h03, 3'h6}, {8'h05, 3'h1}, {8'h05, 3'h4}, {8'h06, 3'h5}};
  int          err_count = 0;
  int          check_count = 0;
  int          hi;
  always #4 sys_clk = ~sys_clk;
  assign pinVec = {padA, antennaOutAOe, padB, antennaOutBOe, driveStyleFault};
  rftx_config_regs rftx_config_regs_i (.sys_clk(sys_clk), .arst_n(arst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
    .regRdStrobe(regRdStrobe), .regRdData(regRdData), .carrierIn(carrierIn),
    .internalEnvelope(internalEnvelope), .externalSignalIn(externalSignalIn),
    .antennaOutA(antennaOutA), .antennaOutAOe(antennaOutAOe), .antennaOutB(antennaOutB),
    .antennaOutBOe(antennaOutBOe), .carrierLevelReductionMv(carrierLevelReductionMv),
    .carrierFull(carrierFull), .residualCarrier(residualCarrier),
    .loadCurrentTrim(loadCurrentTrim), .modulationActive(modulationActive),
    .overshootActive(overshootActive), .driveStyleFault(driveStyleFault));
  rftx_antenna_model rftx_antenna_model_i (.carrierRun(carrierRun),
    .antennaOutA(antennaOutA), .antennaOutAOe(antennaOutAOe), .antennaOutB(antennaOutB),
    .antennaOutBOe(antennaOutBOe), .carrierIn(carrierIn), .padA(padA), .padB(padB));
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  // bus tasks start right after a rising edge and end on one;
  // a write lets one edge pass first so two writes never touch the strobe at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStrobe <= 1'b1;
    @(posedge sys_clk);
    regWrStrobe <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge sys_clk);
    regRdStrobe <= 1'b0;
    @(negedge sys_clk);
    rdVal = regRdData;
    @(posedge sys_clk);
  endtask : rd
  // counts overshoot cycles after an envelope step, sampled mid-cycle
  task automatic count_ovs(input logic env);
    internalEnvelope <= env;
    hi = 0;
    repeat (80)
    begin
      @(negedge sys_clk);
      if (overshootActive === 1'b1)
        hi++;
    end
    @(posedge sys_clk);
  endtask : count_ovs
  // hang guard, far beyond the roughly 560 cycles the tests need
  initial
  begin
    #200000;
    err_count++;
    print_verdict();
  end
  initial
  begin
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    check({9'h0, antennaOutAOe, antennaOutBOe}, 11'h000);
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_DRIVE_MODE + 8'(i), 8'hff);
      rd(ADDR_DRIVE_MODE + 8'(i));
      check({3'h0, rdVal}, {3'h0, maskTbl[i]});
    end
    wr(8'h2c, 8'hff);
    rd(8'h2c);
    check({3'h0, rdVal}, 11'h000);
    check({7'h0, loadCurrentTrim}, 11'h00f);
    check({6'h0, residualCarrier}, 11'h01f);
    $display("test registers done");
    wr(ADDR_OVS_LOAD, 8'h00);
    wr(ADDR_MOD_CTRL, 8'h00);
    // the register test left an overshoot pulse waiting for carrier ticks
    carrierRun <= 1'b1;
    repeat (120) @(posedge sys_clk);
    carrierRun <= 1'b0;
    repeat (8) @(posedge sys_clk);
    check({10'h0, overshootActive}, 11'h000);
    for (int c = 0; c < 4; c++)
    begin
      wr(ADDR_AMPLITUDE, {2'(c), 6'h15});
      repeat (2) @(posedge sys_clk);
      check(carrierLevelReductionMv, mvTbl[c]);
      check({6'h0, residualCarrier}, 11'h015);
    end
    wr(ADDR_MOD_CTRL, 8'h08);
    repeat (2) @(posedge sys_clk);
    check({carrierLevelReductionMv[9:0], carrierFull}, 11'h001);
    wr(ADDR_MOD_CTRL, 8'h00);
    $display("test amplitude done");
    for (int i = 0; i < 12; i++)
    begin
      wr(ADDR_DRIVE_MODE, drvTbl[i][12:5]);
      repeat (3) @(posedge sys_clk);
      check({6'h0, pinVec}, {6'h0, drvTbl[i][4:0]});
    end
    $display("test drive done");
    wr(ADDR_DRIVE_MODE, 8'h08);
    for (int i = 0; i < 9; i++)
    begin
      wr(ADDR_MOD_CTRL, modTbl[i][10:3]);
      internalEnvelope <= modTbl[i][2];
      externalSignalIn <= modTbl[i][1];
      repeat (6) @(posedge sys_clk);
      check({modulationActive, padA}, {9'h0, modTbl[i][0], ~modTbl[i][0]});
    end
    $display("test modulation done");
    wr(ADDR_MOD_CTRL, 8'h01);
    internalEnvelope <= 1'b0;
    wr(ADDR_OVS_LOAD, 8'h30);
    wr(ADDR_MOD_CTRL, 8'h21);
    carrierRun <= 1'b1;
    // let any pulse from the source change drain before the measured edge
    repeat (60) @(posedge sys_clk);
    count_ovs(1'b1);
    check(11'(hi >= 18 && hi <= 34), 11'h001);
    wr(ADDR_OVS_LOAD, 8'h00);
    wr(ADDR_MOD_CTRL, 8'h01);
    count_ovs(1'b0);
    check(11'(hi), 11'h000);
    carrierRun <= 1'b0;
    $display("test overshoot done");
    print_verdict();
  end
endmodule : rftx_config_regs_bench
